// *** logic/event_timer_regs.svh ***
// register map, field positions, reset values and timing counts of the timer bank
// assumes byte addresses relative to the memory-mapped register base
`ifndef EVENT_TIMER_REGS_SVH
`define EVENT_TIMER_REGS_SVH

`define TIMER_BASE_0 32'h0010_0C00
`define TIMER_BASE_1 32'h0010_0C20
`define TIMER_BASE_2 32'h0010_0C40
`define TIMER_BASE_3 32'h0010_0C60
`define TIMER_STRIDE 32'h0000_0020
`define TIMER_BLOCK_MASK 32'hFFFF_FF80
`define TIMER_SEL_LSB 5
`define TIMER_WRAP_LIMIT_OFS 5'h00
`define TIMER_COUNT_OFS 5'h04
`define TIMER_CONTROL_OFS 5'h08

`define IRQ_STATUS_ADDR 32'h0010_0C80
`define IRQ_ENABLE_ADDR 32'h0010_0C84
`define IRQ_CLEAR_ADDR 32'h0010_0C88

`define CTL_RUN_BIT 0
`define CTL_SRC_LSB 4
`define CTL_SRC_MSB 7
`define CTL_WIDTH 8

`define CONTROL_RESET 8'h00
`define COUNT_RESET 32'h0000_0000
`define WRAP_LIMIT_RESET 32'h0000_0000
`define IRQ_RESET 4'h0

`define DIVIDED_CPU_CLOCK_SOURCE_DIV_DEFAULT 16
`define NUM_TIMERS 4

`endif

// *** logic/event_timer_pkg.sv ***
// types shared by the timer bank
// assumes the constants of event_timer_regs.svh
package event_timer_pkg;

  typedef enum logic [3:0] {
    SRC_CPU_CLOCK = 4'b0000,
    SRC_DIVIDED_CPU_CLOCK = 4'b0001,
    SRC_EXT_TIMER_CLOCK = 4'b0010,
    SRC_DATA_BREAKPOINT = 4'b0011,
    SRC_INSTRUCTION_BREAKPOINT = 4'b0100,
    SRC_CACHE_EVENT_ONE = 4'b0101,
    SRC_CACHE_EVENT_TWO = 4'b0110,
    SRC_VIDEO_IN_CLOCK = 4'b0111,
    SRC_VIDEO_OUT_CLOCK = 4'b1000,
    SRC_AUDIO_IN_STROBE = 4'b1001,
    SRC_AUDIO_OUT_STROBE = 4'b1010,
    SRC_SERIAL_RX_SYNC = 4'b1011,
    SRC_SERIAL_TX_SYNC = 4'b1100
  } event_source_t;

  typedef enum logic [1:0] {
    REG_WRAP_LIMIT = 2'b00,
    REG_COUNT = 2'b01,
    REG_CONTROL = 2'b10,
    REG_NONE = 2'b11
  } timer_reg_t;

endpackage : event_timer_pkg

// *** logic/event_timer_counter_bank.sv ***
// bank of four modulo event timer/counters with an apb register slave
// assumes event inputs and pins synchronous to pclk; cache event choice made elsewhere
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "event_timer_regs.svh"

// Overview of operation
// - four identical timers; the fourth is kept for system software only.
// - select values 0..6 pick cpu clock, divided clock, external pin, breakpoints, caches.
// - select values 7..12 pick video, audio and serial pins; 13..15 count nothing.
// - data breakpoint source may add zero, one or two per cycle; others one.
// - pin sources count only rising transitions of the pin.
// - which cache events are counted is chosen outside, by another register.
// - when count plus increment reaches the modulus it wraps to 0 or 1, irq raised.
// - timer irq needs no acknowledge; controller source should be edge mode.
// - timer counts only while its run bit is set, otherwise holds.
// - writing the modulus leaves the count untouched.
// - a store making count equal modulus gives no irq; count runs past and wraps.
// - a zero modulus acts as two to the power 32.
// - reset clears each control register.
// - timer irqs feed controller sources 5, 6, 7 and 8, edge mode.
// - each timer's registers sit at its own base 0x100C00 + 0x20 per timer.
module event_timer_counter_bank
  import event_timer_pkg::*;
#(
  parameter int DIVIDED_CPU_CLOCK_SOURCE_DIV = `DIVIDED_CPU_CLOCK_SOURCE_DIV_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_timer_clock_pin,
  input wire logic [1:0] data_breakpoint_event,
  input wire logic instruction_breakpoint_event,
  input wire logic cache_event_one,
  input wire logic cache_event_two,
  input wire logic video_in_clock_pin,
  input wire logic video_out_clock_pin,
  input wire logic audio_in_word_strobe,
  input wire logic audio_out_word_strobe,
  input wire logic serial_rx_frame_sync,
  input wire logic serial_tx_frame_sync,
  output logic [3:0] timer_irq,
  output logic irq
);

  localparam int NT = `NUM_TIMERS;
  localparam int NPIN = 7;

  logic [31:0] timer_wrap_limit_reg [NT];
  logic [31:0] timer_count_reg [NT];
  logic [`CTL_WIDTH-1:0] timer_control_reg [NT];
  logic [NT-1:0] wrap;
  logic [NT-1:0] irq_status;
  logic [NT-1:0] irq_enable;

  // prescaler shared by all timers; ratio left as a parameter
  logic [15:0] divided_cpu_clock_source_cnt;
  logic divided_cpu_clock_source;
  logic divided_cpu_clock_source_last;

  // one shared divider keeps the divided source in step for every timer
  assign divided_cpu_clock_source_last = divided_cpu_clock_source_cnt == 16'(DIVIDED_CPU_CLOCK_SOURCE_DIV - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divided_cpu_clock_source_cnt <= 16'h0000;
    end else if (divided_cpu_clock_source_last) begin
      divided_cpu_clock_source_cnt <= 16'h0000;
    end else begin
      divided_cpu_clock_source_cnt <= divided_cpu_clock_source_cnt + 16'h0001;
    end
  end

  // one-cycle pulse per divider period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divided_cpu_clock_source <= 1'b0;
    end else begin
      divided_cpu_clock_source <= divided_cpu_clock_source_last;
    end
  end

  // pin edge detection; only rising transitions count
  logic [NPIN-1:0] pin_now;
  logic [NPIN-1:0] pin_prev;
  logic [NPIN-1:0] pin_rise;

  assign pin_now[0] = external_timer_clock_pin;
  assign pin_now[1] = video_in_clock_pin;
  assign pin_now[2] = video_out_clock_pin;
  assign pin_now[3] = audio_in_word_strobe;
  assign pin_now[4] = audio_out_word_strobe;
  assign pin_now[5] = serial_rx_frame_sync;
  assign pin_now[6] = serial_tx_frame_sync;
  assign pin_rise = pin_now & ~pin_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 7'h00;
    end else begin
      pin_prev <= pin_now;
    end
  end

  // apb decode
  logic hit_timer;
  logic [1:0] sel_timer;
  timer_reg_t sel_reg;
  logic hit_status;
  logic hit_enable;
  logic hit_clear;
  logic mapped;
  logic wr_take;
  logic [NT-1:0] clear_req;

  assign hit_timer = (paddr & `TIMER_BLOCK_MASK) == `TIMER_BASE_0;
  assign sel_timer = paddr[`TIMER_SEL_LSB +: 2];
  assign hit_status = paddr == `IRQ_STATUS_ADDR;
  assign hit_enable = paddr == `IRQ_ENABLE_ADDR;
  assign hit_clear = paddr == `IRQ_CLEAR_ADDR;

  always_comb begin
    sel_reg = REG_NONE;
    if (hit_timer) begin
      case (paddr[4:0])
        `TIMER_WRAP_LIMIT_OFS: sel_reg = REG_WRAP_LIMIT;
        `TIMER_COUNT_OFS: sel_reg = REG_COUNT;
        `TIMER_CONTROL_OFS: sel_reg = REG_CONTROL;
        default: sel_reg = REG_NONE;
      endcase
    end
  end

  assign mapped = (sel_reg != REG_NONE) || hit_status || hit_enable || hit_clear;
  // a write lands at the edge where the master sees pready high
  assign wr_take = psel && penable && pready && pwrite && mapped;
  // ones written to the clear word drop the matching status bits
  assign clear_req = (wr_take && hit_clear) ? pwdata[NT-1:0] : 4'h0;

  // one timer per generate pass; timer 3 is the system reserved timer
  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_timer
      logic [1:0] inc;
      logic [1:0] src_inc;
      logic [32:0] eff_limit;
      logic [32:0] sum;
      logic sw_store;
      logic store_limit;
      logic store_count;
      logic store_control;
      logic run;
      logic below_limit;
      logic reaches_limit;
      logic [3:0] src;

      assign src = timer_control_reg[t][`CTL_SRC_MSB:`CTL_SRC_LSB];
      assign run = timer_control_reg[t][`CTL_RUN_BIT];
      // only the three words of this timer count as a store to it
      assign sw_store = wr_take && (sel_reg != REG_NONE) && (sel_timer == 2'(t));
      assign store_limit = sw_store && (sel_reg == REG_WRAP_LIMIT);
      assign store_count = sw_store && (sel_reg == REG_COUNT);
      assign store_control = sw_store && (sel_reg == REG_CONTROL);

      always_comb begin
        src_inc = 2'd0;
        case (src)
          SRC_CPU_CLOCK: src_inc = 2'd1;
          SRC_DIVIDED_CPU_CLOCK: src_inc = {1'b0, divided_cpu_clock_source};
          SRC_EXT_TIMER_CLOCK: src_inc = {1'b0, pin_rise[0]};
          SRC_DATA_BREAKPOINT: src_inc = data_breakpoint_event;
          SRC_INSTRUCTION_BREAKPOINT: src_inc = {1'b0, instruction_breakpoint_event};
          // which cache events these are is chosen outside
          SRC_CACHE_EVENT_ONE: src_inc = {1'b0, cache_event_one};
          SRC_CACHE_EVENT_TWO: src_inc = {1'b0, cache_event_two};
          SRC_VIDEO_IN_CLOCK: src_inc = {1'b0, pin_rise[1]};
          SRC_VIDEO_OUT_CLOCK: src_inc = {1'b0, pin_rise[2]};
          SRC_AUDIO_IN_STROBE: src_inc = {1'b0, pin_rise[3]};
          SRC_AUDIO_OUT_STROBE: src_inc = {1'b0, pin_rise[4]};
          SRC_SERIAL_RX_SYNC: src_inc = {1'b0, pin_rise[5]};
          SRC_SERIAL_TX_SYNC: src_inc = {1'b0, pin_rise[6]};
          // 13..15 count nothing
          default: src_inc = 2'd0;
        endcase
      end

      // a stopped timer holds its count
      assign inc = run ? src_inc : 2'd0;

      // zero limit means a full 2^32 cycle
      assign eff_limit = (timer_wrap_limit_reg[t] == 32'h0000_0000) ?
                         33'h1_0000_0000 : {1'b0, timer_wrap_limit_reg[t]};
      assign sum = {1'b0, timer_count_reg[t]} + {31'h0000_0000, inc};
      // a count already at or past the limit must roll over first
      assign below_limit = {1'b0, timer_count_reg[t]} < eff_limit;
      assign reaches_limit = sum >= eff_limit;
      assign wrap[t] = !sw_store && (inc != 2'd0) && below_limit && reaches_limit;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          timer_control_reg[t] <= `CONTROL_RESET;
        end else if (store_control) begin
          timer_control_reg[t] <= pwdata[`CTL_WIDTH-1:0];
        end
      end

      // store to the limit leaves the count alone
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          timer_wrap_limit_reg[t] <= `WRAP_LIMIT_RESET;
        end else if (store_limit) begin
          timer_wrap_limit_reg[t] <= pwdata;
        end
      end

      // a software store wins over counting in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          timer_count_reg[t] <= `COUNT_RESET;
        end else if (store_count) begin
          timer_count_reg[t] <= pwdata;
        end else if (sw_store) begin
          // any store to this timer skips counting for that cycle
          timer_count_reg[t] <= timer_count_reg[t];
        end else if (wrap[t]) begin
          timer_count_reg[t] <= 32'(sum - eff_limit);
        end else begin
          timer_count_reg[t] <= sum[31:0];
        end
      end
    end
  endgenerate

  // one-cycle request per wrap, to controller sources 5..8; no ack needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= `IRQ_RESET;
    end else begin
      timer_irq <= wrap;
    end
  end

  // sticky status: a wrap in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~clear_req) | wrap;
    end
  end

  // enable gates only the level output; status bits are set regardless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= `IRQ_RESET;
    end else if (wr_take && hit_enable) begin
      irq_enable <= pwdata[NT-1:0];
    end
  end

  // level output; trails the status by one cycle to stay a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // read mux; timer words and bank words are picked apart
  logic [31:0] rd_value;
  logic [31:0] rd_timer;
  logic [31:0] rd_bank;

  always_comb begin
    rd_timer = 32'h0000_0000;
    case (sel_reg)
      REG_WRAP_LIMIT: rd_timer = timer_wrap_limit_reg[sel_timer];
      REG_COUNT: rd_timer = timer_count_reg[sel_timer];
      REG_CONTROL: rd_timer = {24'h00_0000, timer_control_reg[sel_timer]};
      default: rd_timer = 32'h0000_0000;
    endcase
  end

  // the clear word is write only and reads as zero
  always_comb begin
    rd_bank = 32'h0000_0000;
    if (hit_status) begin
      rd_bank = {28'h000_0000, irq_status};
    end else if (hit_enable) begin
      rd_bank = {28'h000_0000, irq_enable};
    end
  end

  assign rd_value = (sel_reg != REG_NONE) ? rd_timer : rd_bank;

  // one wait state: pready rises after the first access cycle, falls after
  logic first_access;

  assign first_access = psel && penable && !pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= first_access;
    end
  end

  // unmapped addresses answer with an error and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= first_access && !mapped;
    end
  end

  // read data stands only with pready, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (first_access && !pwrite) begin
      prdata <= rd_value;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule : event_timer_counter_bank

// *** bench/timer_bank_monitor.sv ***
// checker of apb answers and timer irq pulses
// assumes binding to event_timer_counter_bank
`timescale 1ns/1ps
module timer_bank_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] timer_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // timer words at +0,4,8 of each base, then status, enable, clear
  assign mapped = paddr[1:0] == 2'h0 && ((paddr[31:7] == 25'h0_2018 && paddr[4:0] < 5'h0c)
    || (paddr[31:4] == 28'h010_0C8 && paddr[3:0] < 4'hc));
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence
  a_ready_timing: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without request");
  a_err_gated: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_map_error: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not idle");
  a_clear_reads: assert property (pready && !pwrite && paddr == 32'h0010_0C88 |->
    prdata == 32'h0000_0000)
    else $error("clear register read nonzero");
  a_store_quiet: assert property (psel && penable && pready && pwrite && mapped &&
    paddr[31:7] == 25'h0_2018 |=> timer_irq[$past(paddr[6:5])] == 1'b0)
    else $error("timer irq after a register store");
endmodule : timer_bank_monitor

bind event_timer_counter_bank timer_bank_monitor timer_bank_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq));

// *** bench/event_source_model.sv ***
// far side model: event pulses and pins, reports the increment it caused
// assumes active is raised only while one timer counts
`timescale 1ns/1ps
module event_source_model (
  input wire logic pclk,
  input wire logic active,
  input wire logic [3:0] src,
  output logic ext_pin,
  output logic [1:0] data_bp,
  output logic inst_bp,
  output logic cache_one,
  output logic cache_two,
  output logic [5:0] pins,
  output logic [1:0] inc
);
  initial {ext_pin, data_bp, inst_bp, cache_one, cache_two, pins, inc} = '0;
  // all sources move at once so a wrong select shows up in the count
  always @(posedge pclk) begin : drive
    logic [6:0] lvl;
    logic [6:0] nxt;
    logic [2:0] pulse;
    logic [1:0] dbp;
    lvl = {pins, ext_pin};
    nxt = active ? lvl ^ 7'($urandom) : lvl;
    pulse = active ? 3'($urandom) : 3'h0;
    dbp = active ? 2'($urandom_range(2)) : 2'h0;
    ext_pin <= nxt[0];
    pins <= nxt[6:1];
    {cache_two, cache_one, inst_bp} <= pulse;
    data_bp <= dbp;
    case (src)
      4'h2: inc <= 2'(!lvl[0] && nxt[0]);
      4'h3: inc <= dbp;
      4'h4, 4'h5, 4'h6: inc <= 2'(pulse[src - 4'h4]);
      4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC: inc <= 2'(!lvl[src - 4'h6] && nxt[src - 4'h6]);
      default: inc <= 2'h0;
    endcase
  end
endmodule : event_source_model

// *** bench/event_timer_counter_bank_test.sv ***
// self-checking bench: apb master, count model, wrap and irq checks
// assumes the design, the checker and event_source_model alongside
`timescale 1ns/1ps
module event_timer_counter_bank_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, active, tracking, last_err;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [3:0] timer_irq, ev_src, exp_status;
  logic [1:0] data_bp, ev_inc;
  logic ext_pin, inst_bp, cache_one, cache_two;
  logic [5:0] pins;
  int edge_no, wr_edge, num_errors, check_count, k, s0;
  int seen[4];
  longint m_cnt, m_lim, m_wraps;

  event_timer_counter_bank #(.DIVIDED_CPU_CLOCK_SOURCE_DIV(2)) event_timer_counter_bank_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_timer_clock_pin(ext_pin), .data_breakpoint_event(data_bp),
    .instruction_breakpoint_event(inst_bp), .cache_event_one(cache_one),
    .cache_event_two(cache_two), .video_in_clock_pin(pins[0]), .video_out_clock_pin(pins[1]),
    .audio_in_word_strobe(pins[2]), .audio_out_word_strobe(pins[3]),
    .serial_rx_frame_sync(pins[4]), .serial_tx_frame_sync(pins[5]),
    .timer_irq(timer_irq), .irq(irq));
  event_source_model event_source_model_inst (.pclk(pclk), .active(active), .src(ev_src),
    .ext_pin(ext_pin), .data_bp(data_bp), .inst_bp(inst_bp), .cache_one(cache_one),
    .cache_two(cache_two), .pins(pins), .inc(ev_inc));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic void mstep(input int inc);
    longint e;
    e = (m_lim == 0) ? 64'h1_0000_0000 : m_lim;
    if (m_cnt < e && m_cnt + inc >= e) begin
      m_cnt = m_cnt + inc - e;
      m_wraps++;
    end else begin
      m_cnt = (m_cnt + inc) % 64'h1_0000_0000;
    end
  endfunction : mstep

  always @(posedge pclk) begin
    edge_no <= edge_no + 1;
    if (tracking) mstep(ev_inc);
    for (int t = 0; t < 4; t++) if (timer_irq[t] === 1'b1) seen[t] <= seen[t] + 1;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // write applies and read data is taken at the edge where pready is seen
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    wr_edge = edge_no;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    @(posedge pclk);
  endtask : apb

  task automatic run_case(input int t, input int src, input longint lim, input longint c0,
      input int n);
    int w0;
    logic [31:0] b;
    b = 32'h0010_0C00 + 32'(t) * 32'h0000_0020;
    m_cnt = c0;
    m_lim = lim;
    m_wraps = 0;
    w0 = seen[t];
    apb(1'b1, b + 32'h0000_0004, c0[31:0]);
    apb(1'b1, b, lim[31:0]);
    apb(1'b1, b + 32'h0000_0008, 32'(src * 16 + 1));
    s0 = wr_edge;
    repeat (3) @(posedge pclk);
    ev_src <= 4'(src);
    active <= (n > 0);
    tracking <= 1'b1;
    repeat (n) @(posedge pclk);
    if (n > 0) active <= 1'b0;
    repeat (3) @(posedge pclk);
    tracking <= 1'b0;
    apb(1'b1, b + 32'h0000_0008, 32'(src * 16));
    if (src == 0) repeat (wr_edge - s0 - 1) mstep(1);
    apb(1'b0, b + 32'h0000_0004, '0);
    check("count", m_cnt[31:0], q);
    repeat (2) @(posedge pclk);
    check("wraps", 32'(m_wraps), 32'(seen[t] - w0));
    if (m_wraps > 0) exp_status[t] = 1'b1;
    $display("case timer %0d source %0d done", t, src);
  endtask : run_case

  initial begin
    void'($urandom(66084));
    {presetn, psel, penable, pwrite, active, tracking, last_err} = '0;
    {paddr, pwdata, edge_no, num_errors, check_count, exp_status, ev_src} = '0;
    seen = '{default: 0};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int t = 0; t < 4; t++) begin
      apb(1'b0, 32'h0010_0C08 + 32'(t) * 32'h0000_0020, '0);
      check("control reset", '0, q);
    end
    apb(1'b0, 32'h0010_0C0C, '0);
    check("unmapped", 32'h0000_0001, {31'h0, last_err});
    $display("reset test done");
    run_case(0, 0, 5, 5, 0);
    run_case(1, 0, 0, 64'hFFFF_FFFA, 0);
    for (int s = 2; s < 14; s++) run_case(s % 4, s, 3 + s % 5, 0, 40);
    // divided clock phase is unknown, so either rounding of k/2 passes, with one step of slack below only
    apb(1'b1, 32'h0010_0C20, '0);
    apb(1'b1, 32'h0010_0C24, '0);
    apb(1'b1, 32'h0010_0C28, 32'h0000_0011);
    s0 = wr_edge;
    repeat (20) @(posedge pclk);
    apb(1'b1, 32'h0010_0C28, 32'h0000_0010);
    k = wr_edge - s0 - 1;
    apb(1'b0, 32'h0010_0C24, '0);
    check("divided", 32'h0000_0001, {31'h0, q * 2 + 3 >= k && q * 2 <= k + 1});
    apb(1'b0, 32'h0010_0C80, '0);
    check("status", {28'h0, exp_status}, q);
    check("masked irq", '0, {31'h0, irq});
    apb(1'b1, 32'h0010_0C84, 32'h0000_000F);
    @(posedge pclk);
    check("irq", {31'h0, |exp_status}, {31'h0, irq});
    apb(1'b1, 32'h0010_0C88, 32'h0000_000F);
    @(posedge pclk);
    check("cleared irq", '0, {31'h0, irq});
    apb(1'b0, 32'h0010_0C80, '0);
    check("status cleared", '0, q);
    $display("irq test done");
    final_report();
  end
endmodule : event_timer_counter_bank_test
